// file: verilog/fsafe_pkg.sv
// shared constants, register map and state type of the supervisor
`default_nettype none
package fsafe_pkg;
   // ----------------------------------------
   // timing
   // ----------------------------------------
   localparam int CLK_FREQ_MHZ = 100;
   localparam int US_TICK_CYC = CLK_FREQ_MHZ;
   localparam int FUSE_LOAD_MAX_US = 600;
   localparam int FUSE_LOAD_CYC = FUSE_LOAD_MAX_US * CLK_FREQ_MHZ;
   localparam int PWRUP_LPM_MAX_US = 800;
   localparam int WAKE_CYC = PWRUP_LPM_MAX_US * CLK_FREQ_MHZ;
   localparam int US_PER_MS = 1000;
   localparam int MS_PER_MIN = 60000;
   // debounce lengths in microseconds
   localparam logic [9:0] DBNC_SHORT_US = 10'h00A;
   localparam logic [9:0] DBNC_MID_US = 10'h064;
   localparam logic [9:0] DBNC_LONG_US = 10'h3E8;
   // decay period in minutes, indexed by the fused select
   localparam logic [7:0][5:0] DECAY_MIN = {6'h3C, 6'h2D, 6'h1E, 6'h14,
                                            6'h0F, 6'h0A, 6'h05, 6'h01};
   localparam logic [3:0] COUNT_TOP = 4'hF;
   // ----------------------------------------
   // register map
   // ----------------------------------------
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_STATUS = 8'h04;
   localparam logic [7:0] REG_EVENT = 8'h08;
   localparam logic [7:0] REG_FUSE = 8'h0C;
   localparam int CTRL_OV_EN_BIT = 0;
   localparam int CTRL_OV_SDWN_BIT = 1;
   localparam int CTRL_DBNC_LSB = 2;
   localparam int CTRL_LPM_BIT = 4;
   localparam int CTRL_CNT_CLR_BIT = 5;
   localparam int CTRL_LIMIT_LSB = 8;
   localparam int STAT_CNT_LSB = 0;
   localparam int STAT_STATE_LSB = 4;
   localparam int STAT_OV_BIT = 8;
   localparam int EVT_OVLO_BIT = 0;
   localparam int FUSE_LIMIT_LSB = 0;
   localparam int FUSE_BYPASS_BIT = 4;
   localparam int FUSE_DECAY_LSB = 5;
   localparam int FUSE_OV_EN_BIT = 8;
   localparam int FUSE_OV_SDWN_BIT = 9;
   localparam int FUSE_DBNC_LSB = 10;
   // ----------------------------------------
   // supervisor states
   // ----------------------------------------
   typedef enum logic [2:0] {
      ST_UNPOWERED,
      ST_FUSE_LOAD,
      ST_LOW_POWER_OFF_STATE,
      ST_POWER_UP,
      ST_SYS_ON,
      ST_POWER_DOWN,
      ST_FS_TRANSITION,
      ST_FAILSAFE
   } fsm_state_e;
endpackage
`default_nettype wire

// file: verilog/ovlo_debouncer.sv
// input overvoltage comparator synchroniser and programmable debounce
`timescale 1ns/1ps
`default_nettype none
module ovlo_debouncer
   import fsafe_pkg::*;
(
   input wire logic sys_clk_in,
   input wire logic rst_b_in,
   input wire logic ov_comp_in,
   input wire logic enable_in,
   input wire logic us_tick_in,
   input wire logic [1:0] dbnc_sel_in,
   output logic ov_level_out,
   output logic ov_rise_out
);
   // ----------------------------------------
   // synchroniser
   // ----------------------------------------
   logic [1:0] sync_q; // stage 0 is read by stage 1 only
   logic [9:0] cnt_q; // microseconds seen high
   logic [9:0] limit; // selected debounce length
   logic level_q; // debounced level

   // comparator is asynchronous to the clock
   always_ff @(posedge sys_clk_in or negedge rst_b_in)
   begin
      if (!rst_b_in)
         sync_q <= 2'h0;
      else
         sync_q <= {sync_q[0], ov_comp_in};
   end

   // ----------------------------------------
   // debounce length
   // ----------------------------------------
   // reserved code takes the longest length, the safe side
   always_comb
   begin
      case (dbnc_sel_in)
         2'h0: limit = DBNC_SHORT_US;
         2'h1: limit = DBNC_MID_US;
         default: limit = DBNC_LONG_US;
      endcase
   end

   // high must hold for the full length; low releases at once,
   // the comparator already carries its own hysteresis
   always_ff @(posedge sys_clk_in or negedge rst_b_in)
   begin
      if (!rst_b_in)
      begin
         cnt_q <= 10'h000;
         level_q <= 1'b0;
      end
      else if (!enable_in || !sync_q[1])
      begin
         cnt_q <= 10'h000;
         level_q <= 1'b0;
      end
      else if (us_tick_in && !level_q)
      begin
         if (cnt_q >= limit - 10'h001)
            level_q <= 1'b1;
         else
            cnt_q <= cnt_q + 10'h001;
      end
   end

   // one pulse per debounced rise
   always_ff @(posedge sys_clk_in or negedge rst_b_in)
   begin
      if (!rst_b_in)
         ov_rise_out <= 1'b0;
      else
         ov_rise_out <= enable_in && sync_q[1] && us_tick_in && !level_q && (cnt_q >= limit - 10'h001);
   end

   assign ov_level_out = level_q;
endmodule
`default_nettype wire

// file: verilog/failsafe_and_input_supervisor.sv
// fail-safe lockout, input supply supervision and startup timing
`timescale 1ns/1ps
`default_nettype none
module failsafe_and_input_supervisor
   import fsafe_pkg::*;
#(
   parameter int FUSE_LOAD_CYC_P = FUSE_LOAD_CYC,
   parameter int WAKE_CYC_P = WAKE_CYC,
   parameter int US_CYC_P = US_TICK_CYC,
   parameter int MS_US_P = US_PER_MS,
   parameter int MIN_MS_P = MS_PER_MIN
)
(
   input wire logic sys_clk_in,
   input wire logic rst_b_in,
   // apb slave
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire logic [7:0] paddr_in,
   input wire logic [31:0] pwdata_in,
   output logic [31:0] prdata_out,
   output logic pready_out,
   output logic pslverr_out,
   // analog and pin inputs
   input wire logic above_input_undervoltage_threshold_in,
   input wire logic input_overvoltage_event_in,
   input wire logic power_on_request_pin_in,
   // fuse values from the otp block
   input wire logic [3:0] fused_failsafe_count_limit_in,
   input wire logic fused_lockout_bypass_in,
   input wire logic [2:0] fused_decay_period_sel_in,
   input wire logic fused_overvoltage_monitor_enable_in,
   input wire logic fused_overvoltage_shutdown_select_in,
   input wire logic [1:0] fused_overvoltage_debounce_sel_in,
   // sequencer handshake
   input wire logic fault_off_in,
   input wire logic powerup_done_in,
   input wire logic powerdown_done_in,
   output logic seq_start_out,
   output logic powerdown_req_out,
   output logic failsafe_lock_out,
   output logic fuse_loaded_out,
   output logic ovlo_event_out,
   output logic [2:0] state_out
);
   // ----------------------------------------
   // declarations
   // ----------------------------------------
   logic [1:0] uv_sync_q; // supply comparator synchroniser
   logic [1:0] pin_sync_q; // power-on pin synchroniser
   logic uv_ok; // supply above threshold, synchronised
   logic pin_high; // power-on request, synchronised
   fsm_state_e state_q, state_d; // supervisor state
   logic [16:0] dly_q; // fuse load and wake delay
   logic fault_q; // current power down is a fault
   logic [3:0] cnt_q; // failsafe_event_count
   logic [7:0] us_cnt_q; // microsecond divider
   logic us_tick; // one-cycle microsecond enable
   logic [9:0] ms_cnt_q; // millisecond divider
   logic ms_tick; // one-cycle millisecond enable
   logic [15:0] min_ms_q; // ms within current minute
   logic [5:0] decay_min_q; // minutes of decay period
   logic decay_hit; // decay period elapsed
   logic ov_level; // debounced overvoltage
   logic ov_rise; // debounced overvoltage rise
   logic ov_shut; // overvoltage asks for shutdown
   logic fuse_done; // end of fuse load
   logic wake_ok; // power-up event valid
   logic wake_done; // wake delay elapsed
   // mirror and fuse latches
   logic ov_en_q, ov_sdwn_q, lpm_q;
   logic [1:0] dbnc_q;
   logic [3:0] limit_q; // failsafe_count_limit
   logic [3:0] f_limit_q;
   logic f_bypass_q;
   logic [2:0] f_decay_q;
   logic f_ov_en_q, f_ov_sdwn_q;
   logic [1:0] f_dbnc_q;
   logic ovlo_flag_q; // sticky overvoltage flag
   // apb decode
   logic apb_wr, apb_setup, mapped, clr_wr;
   logic [31:0] rd_mux;

   // ----------------------------------------
   // input synchronisers
   // ----------------------------------------
   // both inputs come from outside the clock domain
   always_ff @(posedge sys_clk_in or negedge rst_b_in)
   begin
      if (!rst_b_in)
      begin
         uv_sync_q <= 2'h0;
         pin_sync_q <= 2'h0;
      end
      else
      begin
         uv_sync_q <= {uv_sync_q[0], above_input_undervoltage_threshold_in};
         pin_sync_q <= {pin_sync_q[0], power_on_request_pin_in};
      end
   end

   assign uv_ok = uv_sync_q[1];
   assign pin_high = pin_sync_q[1];

   // ----------------------------------------
   // time base
   // ----------------------------------------
   // free running divider, one enable per microsecond
   always_ff @(posedge sys_clk_in or negedge rst_b_in)
   begin
      if (!rst_b_in)
         us_cnt_q <= 8'h00;
      else if (us_tick)
         us_cnt_q <= 8'h00;
      else
         us_cnt_q <= us_cnt_q + 8'h01;
   end

   assign us_tick = (us_cnt_q == 8'(US_CYC_P - 1));

   // millisecond enable from the microsecond one
   always_ff @(posedge sys_clk_in or negedge rst_b_in)
   begin
      if (!rst_b_in)
         ms_cnt_q <= 10'h000;
      else if (ms_tick)
         ms_cnt_q <= 10'h000;
      else if (us_tick)
         ms_cnt_q <= ms_cnt_q + 10'h001;
   end

   assign ms_tick = us_tick && (ms_cnt_q == 10'(MS_US_P - 1));

   // ----------------------------------------
   // fail-safe ok timer
   // ----------------------------------------
   // counts only in the on state, clears while the supply is low, holds in the other states; up to one
   // millisecond of phase error is accepted for a minute scale
   always_ff @(posedge sys_clk_in or negedge rst_b_in)
   begin
      if (!rst_b_in)
      begin
         min_ms_q <= 16'h0000;
         decay_min_q <= 6'h00;
      end
      else if (!uv_ok)
      begin
         min_ms_q <= 16'h0000;
         decay_min_q <= 6'h00;
      end
      else if (state_q == ST_SYS_ON && ms_tick)
      begin
         if (min_ms_q == 16'(MIN_MS_P - 1))
         begin
            min_ms_q <= 16'h0000;
            // restart once the selected period is reached
            if (decay_hit)
               decay_min_q <= 6'h00;
            else
               decay_min_q <= decay_min_q + 6'h01;
         end
         else
            min_ms_q <= min_ms_q + 16'h0001;
      end
   end

   // period table indexed by the fused select
   assign decay_hit = (state_q == ST_SYS_ON) && ms_tick
                      && (min_ms_q == 16'(MIN_MS_P - 1))
                      && (decay_min_q == DECAY_MIN[f_decay_q] - 6'h01);

   // ----------------------------------------
   // overvoltage monitor
   // ----------------------------------------
   ovlo_debouncer u_ovlo (
      .sys_clk_in(sys_clk_in),
      .rst_b_in(rst_b_in),
      .ov_comp_in(input_overvoltage_event_in),
      .enable_in(ov_en_q && uv_ok),
      .us_tick_in(us_tick),
      .dbnc_sel_in(dbnc_q),
      .ov_level_out(ov_level),
      .ov_rise_out(ov_rise)
   );

   // in power up the fused select decides, later the mirror bit
   always_comb
   begin
      if (state_q == ST_POWER_UP)
         ov_shut = ov_level && f_ov_sdwn_q;
      else
         ov_shut = ov_level && ov_sdwn_q;
   end

   // ----------------------------------------
   // supervisor state machine
   // ----------------------------------------
   assign fuse_done = (dly_q == 17'(FUSE_LOAD_CYC_P - 1));
   assign wake_ok = pin_high && !ov_shut;
   assign wake_done = (dly_q == 17'(WAKE_CYC_P - 1));

   // next state; a supply drop wins over everything
   always_comb
   begin
      state_d = state_q;
      case (state_q)
         ST_UNPOWERED:
            if (uv_ok)
               state_d = ST_FUSE_LOAD;
         ST_FUSE_LOAD:
            if (fuse_done)
               state_d = ST_LOW_POWER_OFF_STATE;
         ST_LOW_POWER_OFF_STATE:
            // pin already high: 600 + 800 us stays under 1.5 ms
            if (wake_ok && wake_done)
               state_d = ST_POWER_UP;
         ST_POWER_UP:
            if (ov_shut)
               state_d = ST_POWER_DOWN;
            else if (powerup_done_in)
               state_d = ST_SYS_ON;
         ST_SYS_ON:
            if (fault_off_in || !pin_high || ov_shut)
               state_d = ST_POWER_DOWN;
         ST_POWER_DOWN:
            if (powerdown_done_in)
               state_d = fault_q ? ST_FS_TRANSITION : ST_LOW_POWER_OFF_STATE;
         ST_FS_TRANSITION:
            if (!f_bypass_q && cnt_q == limit_q)
               state_d = ST_FAILSAFE;
            else
               state_d = ST_LOW_POWER_OFF_STATE;
         ST_FAILSAFE:
            state_d = ST_FAILSAFE;
         default:
            state_d = ST_UNPOWERED;
      endcase
      if (!uv_ok)
         state_d = ST_UNPOWERED;
   end

   // state register
   always_ff @(posedge sys_clk_in or negedge rst_b_in)
   begin
      if (!rst_b_in)
         state_q <= ST_UNPOWERED;
      else
         state_q <= state_d;
   end

   // delay counter, cleared on every state change
   always_ff @(posedge sys_clk_in or negedge rst_b_in)
   begin
      if (!rst_b_in)
         dly_q <= 17'h00000;
      else if (state_d != state_q)
         dly_q <= 17'h00000;
      else if (state_q == ST_FUSE_LOAD)
         dly_q <= dly_q + 17'h00001;
      else if (state_q == ST_LOW_POWER_OFF_STATE && wake_ok)
         dly_q <= dly_q + 17'h00001;
      else
         dly_q <= 17'h00000;
   end

   // cause of the power down, fixed at its entry
   always_ff @(posedge sys_clk_in or negedge rst_b_in)
   begin
      if (!rst_b_in)
         fault_q <= 1'b0;
      else if (state_d == ST_POWER_DOWN && state_q != ST_POWER_DOWN)
         fault_q <= (state_q == ST_SYS_ON) && fault_off_in;
   end

   // ----------------------------------------
   // fail-safe event counter
   // ----------------------------------------
   // the compare above sees the old value, the increment
   // lands as the transition is left
   always_ff @(posedge sys_clk_in or negedge rst_b_in)
   begin
      if (!rst_b_in)
         cnt_q <= 4'h0;
      else if (!uv_ok)
         cnt_q <= 4'h0;
      else if (state_q == ST_FS_TRANSITION)
      begin
         if (cnt_q != COUNT_TOP)
            cnt_q <= cnt_q + 4'h1;
      end
      else if (clr_wr)
         cnt_q <= 4'h0;
      else if (decay_hit && cnt_q != 4'h0)
         cnt_q <= cnt_q - 4'h1;
   end

   // ----------------------------------------
   // fuse latch and mirror bits
   // ----------------------------------------
   // fuses are taken once per supply cycle, at the end of load
   always_ff @(posedge sys_clk_in or negedge rst_b_in)
   begin
      if (!rst_b_in)
      begin
         f_limit_q <= 4'h0;
         f_bypass_q <= 1'b0;
         f_decay_q <= 3'h0;
         f_ov_en_q <= 1'b0;
         f_ov_sdwn_q <= 1'b0;
         f_dbnc_q <= 2'h0;
      end
      else if (state_q == ST_FUSE_LOAD && fuse_done)
      begin
         f_limit_q <= fused_failsafe_count_limit_in;
         f_bypass_q <= fused_lockout_bypass_in;
         f_decay_q <= fused_decay_period_sel_in;
         f_ov_en_q <= fused_overvoltage_monitor_enable_in;
         f_ov_sdwn_q <= fused_overvoltage_shutdown_select_in;
         f_dbnc_q <= fused_overvoltage_debounce_sel_in;
      end
   end

   // mirror bits: fuse defaults, then software
   always_ff @(posedge sys_clk_in or negedge rst_b_in)
   begin
      if (!rst_b_in)
      begin
         ov_en_q <= 1'b0;
         ov_sdwn_q <= 1'b0;
         dbnc_q <= 2'h0;
         lpm_q <= 1'b0;
         limit_q <= 4'h0;
      end
      else if (state_q == ST_UNPOWERED)
         lpm_q <= 1'b0;
      else if (state_q == ST_FUSE_LOAD && fuse_done)
      begin
         ov_en_q <= fused_overvoltage_monitor_enable_in;
         ov_sdwn_q <= fused_overvoltage_shutdown_select_in;
         dbnc_q <= fused_overvoltage_debounce_sel_in;
         limit_q <= fused_failsafe_count_limit_in;
         lpm_q <= 1'b0;
      end
      else if (apb_wr && paddr_in == REG_CTRL)
      begin
         ov_en_q <= pwdata_in[CTRL_OV_EN_BIT];
         ov_sdwn_q <= pwdata_in[CTRL_OV_SDWN_BIT];
         dbnc_q <= pwdata_in[CTRL_DBNC_LSB +: 2];
         lpm_q <= pwdata_in[CTRL_LPM_BIT];
         limit_q <= pwdata_in[CTRL_LIMIT_LSB +: 4];
      end
   end

   // sticky flag; a new event beats a clear in the same cycle
   always_ff @(posedge sys_clk_in or negedge rst_b_in)
   begin
      if (!rst_b_in)
         ovlo_flag_q <= 1'b0;
      else if (ov_rise)
         ovlo_flag_q <= 1'b1;
      else if (apb_wr && paddr_in == REG_EVENT && pwdata_in[EVT_OVLO_BIT])
         ovlo_flag_q <= 1'b0;
   end

   // ----------------------------------------
   // apb slave
   // ----------------------------------------
   assign apb_setup = psel_in && !penable_in;
   assign apb_wr = psel_in && penable_in && pwrite_in && mapped;
   assign mapped = (paddr_in == REG_CTRL) || (paddr_in == REG_STATUS)
                   || (paddr_in == REG_EVENT) || (paddr_in == REG_FUSE);
   // a clear outside the on state is ignored
   assign clr_wr = apb_wr && (paddr_in == REG_CTRL)
                   && pwdata_in[CTRL_CNT_CLR_BIT] && (state_q == ST_SYS_ON);
   // zero wait states; unmapped access is flagged
   assign pready_out = 1'b1;
   assign pslverr_out = psel_in && penable_in && !mapped;

   // read mux, unused bits read zero
   always_comb
   begin
      rd_mux = 32'h00000000;
      case (paddr_in)
         REG_CTRL:
         begin
            rd_mux[CTRL_OV_EN_BIT] = ov_en_q;
            rd_mux[CTRL_OV_SDWN_BIT] = ov_sdwn_q;
            rd_mux[CTRL_DBNC_LSB +: 2] = dbnc_q;
            rd_mux[CTRL_LPM_BIT] = lpm_q;
            rd_mux[CTRL_LIMIT_LSB +: 4] = limit_q;
         end
         REG_STATUS:
         begin
            rd_mux[STAT_CNT_LSB +: 4] = cnt_q;
            rd_mux[STAT_STATE_LSB +: 3] = state_q;
            rd_mux[STAT_OV_BIT] = ov_level;
         end
         REG_EVENT:
            rd_mux[EVT_OVLO_BIT] = ovlo_flag_q;
         REG_FUSE:
         begin
            rd_mux[FUSE_LIMIT_LSB +: 4] = f_limit_q;
            rd_mux[FUSE_BYPASS_BIT] = f_bypass_q;
            rd_mux[FUSE_DECAY_LSB +: 3] = f_decay_q;
            rd_mux[FUSE_OV_EN_BIT] = f_ov_en_q;
            rd_mux[FUSE_OV_SDWN_BIT] = f_ov_sdwn_q;
            rd_mux[FUSE_DBNC_LSB +: 2] = f_dbnc_q;
         end
         default:
            rd_mux = 32'h00000000;
      endcase
   end

   // read data captured in the setup cycle, stable in access
   always_ff @(posedge sys_clk_in or negedge rst_b_in)
   begin
      if (!rst_b_in)
         prdata_out <= 32'h00000000;
      else if (apb_setup)
         prdata_out <= rd_mux;
   end

   // ----------------------------------------
   // registered outputs
   // ----------------------------------------
   always_ff @(posedge sys_clk_in or negedge rst_b_in)
   begin
      if (!rst_b_in)
      begin
         seq_start_out <= 1'b0;
         powerdown_req_out <= 1'b0;
         failsafe_lock_out <= 1'b0;
         fuse_loaded_out <= 1'b0;
         ovlo_event_out <= 1'b0;
         state_out <= 3'h0;
      end
      else
      begin
         seq_start_out <= (state_d == ST_POWER_UP) && (state_q != ST_POWER_UP);
         powerdown_req_out <= (state_d == ST_POWER_DOWN);
         failsafe_lock_out <= (state_d == ST_FAILSAFE);
         fuse_loaded_out <= (state_d != ST_UNPOWERED) && (state_d != ST_FUSE_LOAD);
         ovlo_event_out <= ov_rise;
         state_out <= state_d;
      end
   end
endmodule
`default_nettype wire

// file: verification/failsafe_and_input_supervisor_checker.sv
// port assertions for the fail-safe and input supervisor
`timescale 1ns/1ps
`default_nettype none
module failsafe_and_input_supervisor_checker
   import fsafe_pkg::*;
#(
   parameter int FUSE_LOAD_CYC_P = FUSE_LOAD_CYC
)
(
   input wire logic sys_clk_in,
   input wire logic rst_b_in,
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic input_overvoltage_event_in,
   input wire logic fused_lockout_bypass_in,
   input wire logic pslverr_out,
   input wire logic seq_start_out,
   input wire logic powerdown_req_out,
   input wire logic failsafe_lock_out,
   input wire logic ovlo_event_out,
   input wire logic [2:0] state_out
);
   // ------
   // helpers
   // ------
   default clocking @(posedge sys_clk_in); endclocking
   default disable iff (!rst_b_in);
   int load_q; // cycles spent loading fuses
   always_ff @(posedge sys_clk_in or negedge rst_b_in)
   begin
      if (!rst_b_in)
         load_q <= 0;
      else
         load_q <= (state_out == ST_FUSE_LOAD) ? load_q + 1 : 0;
   end
   // fault power down into the transition
   sequence s_fs_entry;
      state_out == ST_POWER_DOWN ##1 state_out == ST_FS_TRANSITION;
   endsequence
   // ------
   // assertions
   // ------
   a_fuse_load_time: assert property (load_q <= FUSE_LOAD_CYC_P)
      else $error("fuse load too long");
   a_fs_exit_path: assert property (s_fs_entry |=> state_out inside {ST_LOW_POWER_OFF_STATE, ST_FAILSAFE})
      else $error("bad transition exit");
   a_bypass_to_off: assert property (s_fs_entry ##0 fused_lockout_bypass_in |=> state_out == ST_LOW_POWER_OFF_STATE)
      else $error("bypass not to off");
   a_fault_only: assert property (state_out == ST_FS_TRANSITION |-> $past(state_out) == ST_POWER_DOWN)
      else $error("transition not from power down");
   a_lock_held: assert property (state_out == ST_FAILSAFE |=> state_out inside {ST_FAILSAFE, ST_UNPOWERED})
      else $error("lockout left early");
   a_lock_flag: assert property (failsafe_lock_out == (state_out == ST_FAILSAFE))
      else $error("lock flag wrong");
   a_pdown_level: assert property (powerdown_req_out == (state_out == ST_POWER_DOWN))
      else $error("power down request wrong");
   a_slot_pulse: assert property (seq_start_out == (state_out == ST_POWER_UP && $past(state_out) != ST_POWER_UP))
      else $error("slot start pulse misplaced");
   a_ov_debounced: assert property (ovlo_event_out |-> $past(input_overvoltage_event_in, 8))
      else $error("overvoltage not debounced");
   a_err_access: assert property (pslverr_out |-> psel_in && penable_in)
      else $error("error outside access phase");
endmodule
bind failsafe_and_input_supervisor failsafe_and_input_supervisor_checker #(.FUSE_LOAD_CYC_P(FUSE_LOAD_CYC_P)) u_chk (
   .sys_clk_in(sys_clk_in), .rst_b_in(rst_b_in), .psel_in(psel_in), .penable_in(penable_in),
   .input_overvoltage_event_in(input_overvoltage_event_in), .fused_lockout_bypass_in(fused_lockout_bypass_in),
   .pslverr_out(pslverr_out), .seq_start_out(seq_start_out), .powerdown_req_out(powerdown_req_out),
   .failsafe_lock_out(failsafe_lock_out), .ovlo_event_out(ovlo_event_out), .state_out(state_out)
);
`default_nettype wire

// file: verification/seq_partner.sv
// sequencer stand-in answering power up and power down requests
`timescale 1ns/1ps
`default_nettype none
module seq_partner (
   input wire logic clk_in,
   input wire logic rst_b_in,
   input wire logic start_in,
   input wire logic down_req_in,
   output logic up_done_out,
   output logic down_done_out
);
   // ------
   // slot delay lines
   // ------
   // answers lag by a few slots so an early exit shows up
   logic [4:0] up_q;
   logic [2:0] dn_q;
   always_ff @(posedge clk_in or negedge rst_b_in)
   begin
      if (!rst_b_in)
      begin
         up_q <= 5'h00;
         dn_q <= 3'h0;
      end
      else
      begin
         up_q <= {up_q[3:0], start_in};
         dn_q <= {dn_q[1:0], down_req_in};
      end
   end
   assign up_done_out = up_q[4];
   assign down_done_out = &dn_q & down_req_in; // drops with the request
endmodule
`default_nettype wire

// file: verification/tb_failsafe_and_input_supervisor.sv
// self-checking bench for the fail-safe and input supervisor
`timescale 1ns/1ps
`default_nettype none
module tb_failsafe_and_input_supervisor;
   import fsafe_pkg::*;
   // ------
   // signals
   // ------
   logic clk = 1'h0, rst_b = 1'h0, psel = 1'h0, pen = 1'h0, pwr = 1'h0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic pready, pslverr, perr, sup = 1'h0, ovi = 1'h0, pin = 1'h0, flt = 1'h0;
   logic fbyp = 1'h0, fsd = 1'h0, pud, pdd, seqs, pdr, lock, fld, ovev;
   logic [3:0] flim = 4'h1;
   logic [2:0] fdec = 3'h7, st;
   int error_cnt = 0, n_compared = 0, cyc = 0;
   always #5 clk = ~clk;
   failsafe_and_input_supervisor #(.FUSE_LOAD_CYC_P(20), .WAKE_CYC_P(20),
      .US_CYC_P(2), .MS_US_P(3), .MIN_MS_P(4)) u_dut (
      .sys_clk_in(clk), .rst_b_in(rst_b), .psel_in(psel), .penable_in(pen),
      .pwrite_in(pwr), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
      .pready_out(pready), .pslverr_out(pslverr),
      .above_input_undervoltage_threshold_in(sup), .input_overvoltage_event_in(ovi),
      .power_on_request_pin_in(pin), .fused_failsafe_count_limit_in(flim),
      .fused_lockout_bypass_in(fbyp), .fused_decay_period_sel_in(fdec),
      .fused_overvoltage_monitor_enable_in(!fsd),
      .fused_overvoltage_shutdown_select_in(fsd),
      .fused_overvoltage_debounce_sel_in({1'h0, fsd}), .fault_off_in(flt),
      .powerup_done_in(pud), .powerdown_done_in(pdd), .seq_start_out(seqs),
      .powerdown_req_out(pdr), .failsafe_lock_out(lock), .fuse_loaded_out(fld),
      .ovlo_event_out(ovev), .state_out(st));
   seq_partner u_seq (.clk_in(clk), .rst_b_in(rst_b), .start_in(seqs),
      .down_req_in(pdr), .up_done_out(pud), .down_done_out(pdd));
   // ------
   // tasks
   // ------
   task automatic chk(input string nm, input logic [31:0] exp, got);
      n_compared++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("mismatch %s expected %h seen %h", nm, exp, got);
      end
   endtask
   // one apb transfer, held until pready is seen high
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'h1;
      pwr <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      pen <= 1'h1;
      @(posedge clk);
      while (pready !== 1'h1)
         @(posedge clk);
      rd = prdata;
      perr = pslverr;
      psel <= 1'h0;
      pen <= 1'h0;
   endtask
   task automatic wst(input logic [2:0] s);
      @(negedge clk);
      while (st !== s)
         @(negedge clk);
   endtask
   task automatic fault;
      @(posedge clk);
      flt <= 1'h1;
      wst(ST_POWER_DOWN);
      @(posedge clk);
      flt <= 1'h0;
   endtask
   // supply cycle, the only way out of lockout
   task automatic cycsup;
      @(posedge clk);
      sup <= 1'h0;
      wst(ST_UNPOWERED);
      @(posedge clk);
      sup <= 1'h1;
      wst(ST_SYS_ON);
   endtask
   task automatic end_of_test;
      if (error_cnt == 0 && n_compared > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   // hang guard, far above the cycles needed
   always @(posedge clk)
   begin
      cyc <= cyc + 1;
      if (cyc == 20000)
      begin
         error_cnt++;
         end_of_test();
      end
   end
   // ------
   // scenarios
   // ------
   initial
   begin
      repeat (6) @(posedge clk);
      rst_b <= 1'h1;
      @(posedge clk);
      sup <= 1'h1;
      pin <= 1'h1;
      wst(ST_SYS_ON);
      chk("loaded", 32'h1, {31'h0, fld});
      apb(1'h0, REG_FUSE, 32'h0);
      chk("fuse", 32'h1E1, rd);
      apb(1'h0, REG_CTRL, 32'h0);
      chk("ctrl", 32'h101, rd);
      apb(1'h0, 8'h10, 32'h0);
      chk("slverr", 32'h1, {31'h0, perr});
      ovi <= 1'h1;
      apb(1'h0, REG_EVENT, 32'h0);
      chk("early flag", 32'h0, rd);
      repeat (30) @(posedge clk);
      apb(1'h0, REG_EVENT, 32'h0);
      chk("ov flag", 32'h1, rd);
      chk("still on", 32'h4, {29'h0, st});
      ovi <= 1'h0;
      apb(1'h1, REG_CTRL, 32'h103);
      ovi <= 1'h1;
      wst(ST_POWER_DOWN);
      @(posedge clk);
      ovi <= 1'h0;
      wst(ST_SYS_ON);
      fault();
      wst(ST_SYS_ON);
      apb(1'h0, REG_STATUS, 32'h0);
      chk("count", 32'h1, {28'h0, rd[3:0]});
      fault();
      wst(ST_FAILSAFE);
      chk("lock", 32'h1, {31'h0, lock});
      repeat (100) @(posedge clk);
      chk("held", 32'h7, {29'h0, st});
      flim <= 4'h0;
      fsd <= 1'h1;
      cycsup();
      apb(1'h0, REG_STATUS, 32'h0);
      chk("count", 32'h0, {28'h0, rd[3:0]});
      apb(1'h0, REG_CTRL, 32'h0);
      chk("defaults", 32'h6, rd);
      apb(1'h1, REG_CTRL, 32'h001);
      fault();
      wst(ST_FAILSAFE);
      @(posedge clk);
      fbyp <= 1'h1;
      fdec <= 3'h6;
      cycsup();
      fault();
      wst(ST_SYS_ON);
      fault();
      wst(ST_SYS_ON);
      apb(1'h1, REG_CTRL, 32'h121);
      apb(1'h0, REG_STATUS, 32'h0);
      chk("cleared", 32'h0, {28'h0, rd[3:0]});
      fault();
      wst(ST_SYS_ON);
      repeat (1000) @(posedge clk);
      apb(1'h0, REG_STATUS, 32'h0);
      chk("not decayed", 32'h1, {28'h0, rd[3:0]});
      repeat (100) @(posedge clk);
      apb(1'h0, REG_STATUS, 32'h0);
      chk("decayed", 32'h0, {28'h0, rd[3:0]});
      end_of_test();
   end
endmodule
`default_nettype wire
